// File: hw/irqsc_regs.vh
`ifndef IRQSC_REGS_VH
`define IRQSC_REGS_VH

// register byte addresses
`define IRQSC_A_TFLAGS   8'h38
`define IRQSC_A_TEN      8'h3C
`define IRQSC_A_CCTL     8'h40
`define IRQSC_A_GEN      8'h44
`define IRQSC_A_GFLAGS   8'h48
`define IRQSC_A_CFLAGS   8'h4C

// field positions
`define IRQSC_B_OVF      1
`define IRQSC_B_PUK      6
`define IRQSC_B_SLP      5
`define IRQSC_B_DEPTH    4
`define IRQSC_B_SHI      1
`define IRQSC_B_SLO      0
`define IRQSC_B_EXT      6
`define IRQSC_B_PC       5
`define IRQSC_B_GIE      7

// reset value of every register
`define IRQSC_RST8       8'h00

// pulled-up idle level of the port pins, seeds the change detector
`define IRQSC_PIN_IDLE   6'h3F

// external sense encodings
`define IRQSC_SNS_LOW    2'h0
`define IRQSC_SNS_ANY    2'h1
`define IRQSC_SNS_FALL   2'h2
`define IRQSC_SNS_RISE   2'h3

// vector addresses, program counter is 9 bits
`define IRQSC_VEC_EXT    9'h001
`define IRQSC_VEC_PC     9'h002
`define IRQSC_VEC_OVF    9'h003

// cycle counts, counter holds the count minus one
`define IRQSC_ENTRY_LAST 16'h0003
`define IRQSC_SLEEP_ADD  16'h0004
`define IRQSC_RET_LAST   16'h0003
`define IRQSC_PC_DEFER   2'h2
`define IRQSC_CNT_ZERO   16'h0000
`define IRQSC_CNT_ONE    16'h0001
`define IRQSC_LO_PINS    3

`endif

// File: hw/irqsc_top.v
// Contract
// - overflow vector needs enable, global, flag
// - overflow flag: set on overflow, cleared twice
// - external pin triggers even as output
// - low level requests while low, no flag
// - low pins always, high pins if input
// - pin change fires regardless of other interrupts
// - pins sampled by clock before change detect
// - entry takes four cycles, pushes counter
// - finish current instruction before entry
// - sleep wake adds four entry cycles
// - return takes four cycles, sets global
// - one instruction runs after return
// - pull-up disable bit kills all pull-ups
// - sleep only when sleep enable set
// - depth bit: idle zero, power down one
// - sense bits choose level or edge type
// - pin sampled first; level held to boundary
// - enabled interrupt wakes, handler, resume
// - pin-change wake: two instructions run first; the code defers only after a power-down wake, an idle wake enters at once
// - idle halts cpu, resumes immediately
// - power down wakes only on level/change
// - taking interrupt clears global enable
//
// The implementer's own choice: the APB slave port.
`include "irqsc_regs.vh"
module irqsc_top #(
    parameter        HAS_PULLUP_KILL = 1,
    parameter        EXT_SLEEP_RESP  = 1,
    parameter [15:0] WAKE_HOLD       = 16'h0010
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_ovf,
    input  wire        ext_irq_pin,
    input  wire [5:0]  port_pins,
    input  wire [2:0]  pin_cfg_hi,
    input  wire        insn_done,
    input  wire        sleep_cmd,
    input  wire        irq_return_instruction_cmd,
    output reg         cpu_stall,
    output reg         pc_push,
    output reg         pc_pop,
    output reg         vec_load,
    output reg  [8:0]  vec_addr,
    output reg         idle_mode,
    output reg         power_down,
    output reg         pullup_kill
);

    localparam [4:0] ST_RUN   = 5'h01;
    localparam [4:0] ST_ENTRY = 5'h02;
    localparam [4:0] ST_RET   = 5'h04;
    localparam [4:0] ST_SLEEP = 5'h08;
    localparam [4:0] ST_HOLD  = 5'h10;

    // address match, shared by read mux and write strobes
    function hit;
        input [7:0] a;
        input [7:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    reg  [4:0]  state;
    reg  [15:0] cnt;
    reg         ovf_flag;
    reg         ovf_irq_enable;
    reg         sleep_allow;
    reg         sleep_depth_select;
    reg         ext_sense_hi;
    reg         ext_sense_lo;
    reg         ext_en;
    reg         pc_en;
    reg         ext_flag;
    reg         pc_flag;
    reg         gie;
    reg         block_one;
    reg         woke;
    reg         pc_woke;
    reg  [1:0]  pc_defer;
    reg         ext_s;
    reg         ext_p;
    reg  [5:0]  pin_s;
    reg  [5:0]  pin_p;
    reg  [31:0] rd_data;
    reg         rd_bad;
    reg         ext_edge;
    wire [5:0]  chg;
    wire [1:0]  sense;
    wire        ext_level;
    wire        wr;
    wire        req_ext;
    wire        req_pc;
    wire        req_ovf;
    wire        any_req;
    wire        take;
    wire        idle_wake;
    wire        pd_wake;
    wire        hold_ok;
    wire        clr_ext;
    wire        clr_pc;
    wire        clr_ovf;

    assign wr = psel & penable & pwrite & pready;
    assign sense = {ext_sense_hi, ext_sense_lo};

    // pin change per pin; high pins only count when configured as input
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_chg
            if (i < `IRQSC_LO_PINS) begin : g_lo
                assign chg[i] = pin_s[i] ^ pin_p[i];
            end else begin : g_hi
                assign chg[i] = (pin_s[i] ^ pin_p[i])
                                & pin_cfg_hi[i - `IRQSC_LO_PINS];
            end
        end
    endgenerate

    // external trigger decode; pin direction is never looked at
    assign ext_level = (sense == `IRQSC_SNS_LOW) & ~ext_s;
    always @* begin
        case (sense)
            `IRQSC_SNS_ANY:  ext_edge = ext_s ^ ext_p;
            `IRQSC_SNS_FALL: ext_edge = ~ext_s & ext_p;
            `IRQSC_SNS_RISE: ext_edge = ext_s & ~ext_p;
            default:         ext_edge = 1'b0;
        endcase
    end

    // level request is live, not remembered; must hold to the boundary
    assign req_ext = ext_en & (ext_level | ext_flag);
    // the boundary that ends the last deferred instruction may already take it
    assign req_pc  = pc_en & pc_flag & ((pc_defer == 2'h0)
                     | ((pc_defer == 2'h1) & insn_done));
    assign req_ovf = ovf_irq_enable & ovf_flag;
    assign any_req = req_ext | req_pc | req_ovf;

    // entry only at an instruction boundary or right after waking
    assign take = (state == ST_RUN) & (insn_done | woke) & gie
                  & ~block_one & any_req;

    assign clr_ext = (take & req_ext) | (wr & hit(paddr, `IRQSC_A_GFLAGS)
                     & pwdata[`IRQSC_B_EXT]);
    assign clr_pc  = (take & ~req_ext & req_pc) | (wr & hit(paddr, `IRQSC_A_GFLAGS)
                     & pwdata[`IRQSC_B_PC]);
    assign clr_ovf = (take & ~req_ext & ~req_pc) | (wr & hit(paddr, `IRQSC_A_TFLAGS)
                     & pwdata[`IRQSC_B_OVF]);

    // idle wakes on any enabled source; power down only on level or change
    assign idle_wake = ~sleep_depth_select & (req_ext | (pc_en & pc_flag) | req_ovf);
    assign pd_wake   = sleep_depth_select
                       & ((ext_en & ext_level) | (pc_en & pc_flag));
    assign hold_ok   = (ext_en & ext_level) | (pc_en & pc_flag & (pin_s == pin_p));

    // read mux; unmapped addresses answer with an error
    always @* begin
        rd_data = 32'h0000_0000;
        rd_bad  = 1'b0;
        if (hit(paddr, `IRQSC_A_TFLAGS)) begin
            rd_data[`IRQSC_B_OVF] = ovf_flag;
        end else if (hit(paddr, `IRQSC_A_TEN)) begin
            rd_data[`IRQSC_B_OVF] = ovf_irq_enable;
        end else if (hit(paddr, `IRQSC_A_CCTL)) begin
            rd_data[`IRQSC_B_PUK]   = pullup_kill;
            rd_data[`IRQSC_B_SLP]   = sleep_allow;
            rd_data[`IRQSC_B_DEPTH] = sleep_depth_select;
            rd_data[`IRQSC_B_SHI]   = ext_sense_hi;
            rd_data[`IRQSC_B_SLO]   = ext_sense_lo;
        end else if (hit(paddr, `IRQSC_A_GEN)) begin
            rd_data[`IRQSC_B_EXT] = ext_en;
            rd_data[`IRQSC_B_PC]  = pc_en;
        end else if (hit(paddr, `IRQSC_A_GFLAGS)) begin
            rd_data[`IRQSC_B_EXT] = ext_flag;
            rd_data[`IRQSC_B_PC]  = pc_flag;
        end else if (hit(paddr, `IRQSC_A_CFLAGS)) begin
            rd_data[`IRQSC_B_GIE] = gie;
        end else begin
            rd_bad = 1'b1;
        end
    end

    // apb slave: one wait state, write lands on the pready edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= rd_bad;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // pins sampled once on the clock, previous sample kept for edges
    // seeded at the idle level so release of reset shows no false change;
    // a pin held low through reset still reports one change
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s <= 1'b1;
            ext_p <= 1'b1;
            pin_s <= `IRQSC_PIN_IDLE;
            pin_p <= `IRQSC_PIN_IDLE;
        end else begin
            ext_s <= ext_irq_pin;
            ext_p <= ext_s;
            pin_s <= port_pins;
            pin_p <= pin_s;
        end
    end

    // software-written control; sense edits while enabled are software's risk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_irq_enable     <= 1'b0;
            pullup_kill        <= 1'b0;
            sleep_allow        <= 1'b0;
            sleep_depth_select <= 1'b0;
            ext_sense_hi       <= 1'b0;
            ext_sense_lo       <= 1'b0;
            ext_en             <= 1'b0;
            pc_en              <= 1'b0;
        end else if (wr) begin
            if (hit(paddr, `IRQSC_A_TEN)) begin
                ovf_irq_enable <= pwdata[`IRQSC_B_OVF];
            end
            if (hit(paddr, `IRQSC_A_CCTL)) begin
                // bit stays zero on variants without pull-up control
                pullup_kill        <= (HAS_PULLUP_KILL != 0) & pwdata[`IRQSC_B_PUK];
                sleep_allow        <= pwdata[`IRQSC_B_SLP];
                sleep_depth_select <= pwdata[`IRQSC_B_DEPTH];
                ext_sense_hi       <= pwdata[`IRQSC_B_SHI];
                ext_sense_lo       <= pwdata[`IRQSC_B_SLO];
            end
            if (hit(paddr, `IRQSC_A_GEN)) begin
                ext_en <= pwdata[`IRQSC_B_EXT];
                pc_en  <= pwdata[`IRQSC_B_PC];
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag <= 1'b0;
            ext_flag <= 1'b0;
            pc_flag  <= 1'b0;
        end else begin
            ovf_flag <= (ovf_flag & ~clr_ovf) | timer_ovf;
            ext_flag <= (sense == `IRQSC_SNS_LOW) ? 1'b0
                        : ((ext_flag & ~clr_ext) | ext_edge);
            pc_flag  <= (pc_flag & ~clr_pc) | (|chg);
        end
    end

    // sequencer for entry, return and sleep
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_RUN;
            cnt        <= `IRQSC_CNT_ZERO;
            gie        <= 1'b0;
            block_one  <= 1'b0;
            woke       <= 1'b0;
            pc_woke    <= 1'b0;
            pc_defer   <= 2'h0;
            cpu_stall  <= 1'b0;
            pc_push    <= 1'b0;
            pc_pop     <= 1'b0;
            vec_load   <= 1'b0;
            vec_addr   <= `IRQSC_VEC_EXT;
            idle_mode  <= 1'b0;
            power_down <= 1'b0;
        end else begin
            pc_push  <= 1'b0;
            pc_pop   <= 1'b0;
            vec_load <= 1'b0;
            woke     <= 1'b0;
            if (wr & hit(paddr, `IRQSC_A_CFLAGS)) begin
                gie <= pwdata[`IRQSC_B_GIE];
            end
            if (insn_done & (pc_defer != 2'h0)) begin
                pc_defer <= pc_defer - 2'h1;
            end
            case (state)
                ST_RUN: begin
                    if (insn_done) begin
                        block_one <= 1'b0;
                    end
                    if (take) begin
                        state     <= ST_ENTRY;
                        gie       <= 1'b0;
                        cpu_stall <= 1'b1;
                        pc_push   <= 1'b1;
                        vec_addr  <= req_ext ? `IRQSC_VEC_EXT
                                     : (req_pc ? `IRQSC_VEC_PC : `IRQSC_VEC_OVF);
                        cnt       <= (woke & (EXT_SLEEP_RESP != 0))
                                     ? `IRQSC_ENTRY_LAST + `IRQSC_SLEEP_ADD
                                     : `IRQSC_ENTRY_LAST;
                    end else if (irq_return_instruction_cmd) begin
                        state     <= ST_RET;
                        cpu_stall <= 1'b1;
                        pc_pop    <= 1'b1;
                        cnt       <= `IRQSC_RET_LAST;
                    end else if (sleep_cmd & sleep_allow) begin
                        state      <= ST_SLEEP;
                        cpu_stall  <= 1'b1;
                        idle_mode  <= ~sleep_depth_select;
                        power_down <= sleep_depth_select;
                    end
                end
                ST_ENTRY: begin
                    cnt <= cnt - `IRQSC_CNT_ONE;
                    if (cnt == `IRQSC_CNT_ZERO) begin
                        state     <= ST_RUN;
                        cpu_stall <= 1'b0;
                        vec_load  <= 1'b1;
                    end
                end
                ST_RET: begin
                    cnt <= cnt - `IRQSC_CNT_ONE;
                    if (cnt == `IRQSC_CNT_ZERO) begin
                        state     <= ST_RUN;
                        cpu_stall <= 1'b0;
                        gie       <= 1'b1;
                        block_one <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (idle_wake) begin
                        // idle restarts at once, handler follows if enabled
                        state     <= ST_RUN;
                        cpu_stall <= 1'b0;
                        idle_mode <= 1'b0;
                        woke      <= 1'b1;
                    end else if (pd_wake) begin
                        state   <= ST_HOLD;
                        pc_woke <= ~(ext_en & ext_level);
                        cnt     <= WAKE_HOLD - `IRQSC_CNT_ONE;
                    end
                end
                ST_HOLD: begin
                    cnt <= cnt - `IRQSC_CNT_ONE;
                    if (~hold_ok) begin
                        // source vanished before the hold ran out: stay asleep
                        state <= ST_SLEEP;
                    end else if (cnt == `IRQSC_CNT_ZERO) begin
                        state      <= ST_RUN;
                        cpu_stall  <= 1'b0;
                        power_down <= 1'b0;
                        woke       <= 1'b1;
                        pc_defer   <= pc_woke ? `IRQSC_PC_DEFER : 2'h0;
                    end
                end
                default: begin
                    state     <= ST_RUN;
                    cpu_stall <= 1'b0;
                end
            endcase
        end
    end

endmodule

// File: tb/irqsc_assertions.sv
module irqsc_checker (
    input logic       pclk,
    input logic       presetn,
    input logic       sleep_cmd,
    input logic       irq_return_instruction_cmd,
    input logic       cpu_stall,
    input logic       pc_push,
    input logic       pc_pop,
    input logic       vec_load,
    input logic [8:0] vec_addr,
    input logic       idle_mode,
    input logic       power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vec_legal: assert property (
        vec_load |-> vec_addr inside {9'h001, 9'h002, 9'h003})
        else $error("jump to an unknown vector");
    a_entry_min: assert property (
        pc_push |=> (cpu_stall && !vec_load) [*3])
        else $error("interrupt entry shorter than four cycles");
    a_entry_bound: assert property (
        pc_push |-> ##[4:8] vec_load)
        else $error("vector load late after push");
    a_vec_release: assert property (
        vec_load |-> !cpu_stall)
        else $error("core still held at vector load");
    a_return_len: assert property (
        pc_pop |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("return does not hold the core four cycles");
    a_pop_cause: assert property (
        pc_pop |-> $past(irq_return_instruction_cmd))
        else $error("pop without a return instruction");
    a_sleep_cause: assert property (
        $rose(idle_mode || power_down) |-> $past(sleep_cmd))
        else $error("sleep entered without a sleep instruction");
    a_mode_excl: assert property (
        !(idle_mode && power_down))
        else $error("idle and power down at once");
    a_sleep_hold: assert property (
        (idle_mode || power_down) |-> cpu_stall)
        else $error("core runs while asleep");
endmodule

// File: tb/irqsc_pins.sv
module irqsc_pins (
    input  logic       pclk,
    output logic       ext_irq_pin,
    output logic [5:0] port_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-ups keep the pins high when nothing drives them
    initial begin
        ext_irq_pin = 1'b1;
        port_pins   = 6'h3F;
    end
    // levels stay several clocks so the input sampler surely sees them
    task automatic set_ext(input logic v);
        ext_irq_pin <= v;
        repeat (4) @(posedge pclk);
    endtask
    // two-clock pulse, longer than one clock period
    task automatic blip(input int k);
        port_pins[k] <= ~port_pins[k];
        repeat (2) @(posedge pclk);
        port_pins[k] <= ~port_pins[k];
        repeat (4) @(posedge pclk);
    endtask
    // lasting change, kept well past the wake hold
    task automatic flip(input int k);
        port_pins[k] <= ~port_pins[k];
    endtask
endmodule

// File: tb/tb_top.sv
`include "irqsc_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, e;
    logic        timer_ovf, insn_done, sleep_cmd, irq_return_instruction_cmd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  pin_cfg_hi;
    logic        pready, pslverr, cpu_stall, pc_push, pc_pop, vec_load;
    logic        idle_mode, power_down, pullup_kill, ext_irq_pin;
    logic [8:0]  vec_addr;
    logic [5:0]  port_pins;
    int          n_errors, cmp_count, i;

    // short wake hold keeps the power-down case quick
    irqsc_top #(.WAKE_HOLD(16'h0004)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf),
        .ext_irq_pin(ext_irq_pin), .port_pins(port_pins), .pin_cfg_hi(pin_cfg_hi),
        .insn_done(insn_done), .sleep_cmd(sleep_cmd), .irq_return_instruction_cmd(irq_return_instruction_cmd),
        .cpu_stall(cpu_stall), .pc_push(pc_push), .pc_pop(pc_pop),
        .vec_load(vec_load), .vec_addr(vec_addr), .idle_mode(idle_mode),
        .power_down(power_down), .pullup_kill(pullup_kill));
    irqsc_pins pins (.pclk(pclk), .ext_irq_pin(ext_irq_pin), .port_pins(port_pins));

    // 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic give_up();
        n_errors++;
        $display("wrong value at %0t: wait timed out", $time);
        print_verdict();
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // one bus transfer; the answer is taken only at the edge with pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) give_up();
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never rewrites psel in this step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    // two back-to-back instruction boundaries
    task automatic bound2();
        insn_done <= 1'b1;
        step(2);
        insn_done <= 1'b0;
    endtask
    task automatic ovf_pulse();
        timer_ovf <= 1'b1;
        step(1);
        timer_ovf <= 1'b0;
        step(2);
    endtask
    task automatic sleep_pulse();
        sleep_cmd <= 1'b1;
        step(1);
        sleep_cmd <= 1'b0;
        step(2);
    endtask
    // c of zero skips the cycle count, used where the wake delay is open
    task automatic wait_vec(input logic [8:0] a, input int c);
        int n;
        n = 0;
        while (pc_push !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 40) give_up();
        chk(32'(vec_addr), 32'(a));
        n = 0;
        while (vec_load !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) give_up();
        if (c > 0) chk(32'(n), 32'(c));
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {timer_ovf, insn_done, sleep_cmd, irq_return_instruction_cmd, pin_cfg_hi} = '0;
        n_errors = 0;
        cmp_count = 0;
        step(12);
        presetn <= 1'b1;
        step(1);
        // reset contents, then an unmapped word
        for (i = 0; i < 6; i++) rd(8'h38 + 8'(4 * i), 32'h0000_0000);
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        // overflow flag set by the timer, cleared by writing one
        wr(`IRQSC_A_TEN, 32'h0000_0002);
        ovf_pulse();
        rd(`IRQSC_A_TFLAGS, 32'h0000_0002);
        wr(`IRQSC_A_TFLAGS, 32'h0000_0002);
        rd(`IRQSC_A_TFLAGS, 32'h0000_0000);
        // overflow entry waits for the instruction boundary
        ovf_pulse();
        wr(`IRQSC_A_CFLAGS, 32'h0000_0080);
        step(3);
        chk(32'(cpu_stall), 32'h0000_0000);
        bound2();
        wait_vec(`IRQSC_VEC_OVF, 4);
        rd(`IRQSC_A_CFLAGS, 32'h0000_0000);
        rd(`IRQSC_A_TFLAGS, 32'h0000_0000);
        // pending overflow must wait one instruction after the return
        ovf_pulse();
        irq_return_instruction_cmd <= 1'b1;
        step(1);
        irq_return_instruction_cmd <= 1'b0;
        step(8);
        rd(`IRQSC_A_CFLAGS, 32'h0000_0080);
        insn_done <= 1'b1;
        step(1);
        insn_done <= 1'b0;
        step(2);
        chk(32'(cpu_stall), 32'h0000_0000);
        bound2();
        wait_vec(`IRQSC_VEC_OVF, 4);
        // edge sense codes, enable dropped around each change
        for (i = 1; i < 4; i++) begin
            wr(`IRQSC_A_GEN, 32'h0000_0000);
            wr(`IRQSC_A_CCTL, 32'(i));
            wr(`IRQSC_A_GEN, 32'h0000_0040);
            wr(`IRQSC_A_GFLAGS, 32'h0000_0060);
            pins.set_ext(1'b0);
            rd(`IRQSC_A_GFLAGS, (i != 3) ? 32'h0000_0040 : 32'h0000_0000);
            wr(`IRQSC_A_GFLAGS, 32'h0000_0040);
            pins.set_ext(1'b1);
            rd(`IRQSC_A_GFLAGS, (i != 2) ? 32'h0000_0040 : 32'h0000_0000);
        end
        // low level: no flag kept, but the request is served
        wr(`IRQSC_A_GEN, 32'h0000_0000);
        wr(`IRQSC_A_CCTL, 32'h0000_0000);
        wr(`IRQSC_A_GFLAGS, 32'h0000_0060);
        pins.set_ext(1'b0);
        rd(`IRQSC_A_GFLAGS, 32'h0000_0000);
        wr(`IRQSC_A_GEN, 32'h0000_0040);
        wr(`IRQSC_A_CFLAGS, 32'h0000_0080);
        bound2();
        wait_vec(`IRQSC_VEC_EXT, 4);
        pins.set_ext(1'b1);
        // high port pins count only when configured as inputs
        wr(`IRQSC_A_GFLAGS, 32'h0000_0060);
        pins.blip(4);
        rd(`IRQSC_A_GFLAGS, 32'h0000_0000);
        pin_cfg_hi <= 3'h2;
        pins.blip(4);
        rd(`IRQSC_A_GFLAGS, 32'h0000_0020);
        wr(`IRQSC_A_GFLAGS, 32'h0000_0020);
        pins.blip(1);
        rd(`IRQSC_A_GFLAGS, 32'h0000_0020);
        // pull-up kill bit reaches its pin
        wr(`IRQSC_A_CCTL, 32'h0000_0040);
        step(1);
        chk(32'(pullup_kill), 32'h0000_0001);
        rd(`IRQSC_A_CCTL, 32'h0000_0040);
        // sleep refused without the allow bit, then idle and an overflow wake
        wr(`IRQSC_A_GFLAGS, 32'h0000_0060);
        wr(`IRQSC_A_GEN, 32'h0000_0000);
        wr(`IRQSC_A_CFLAGS, 32'h0000_0080);
        wr(`IRQSC_A_CCTL, 32'h0000_0000);
        sleep_pulse();
        chk(32'(cpu_stall), 32'h0000_0000);
        wr(`IRQSC_A_CCTL, 32'h0000_0020);
        sleep_pulse();
        chk(32'(idle_mode), 32'h0000_0001);
        ovf_pulse();
        wait_vec(`IRQSC_VEC_OVF, 8);
        chk(32'(idle_mode), 32'h0000_0000);
        // power down, woken by a lasting pin change
        wr(`IRQSC_A_GEN, 32'h0000_0020);
        wr(`IRQSC_A_CFLAGS, 32'h0000_0080);
        wr(`IRQSC_A_CCTL, 32'h0000_0030);
        sleep_pulse();
        chk(32'(power_down), 32'h0000_0001);
        pins.flip(0);
        step(2);
        chk(32'(power_down), 32'h0000_0001);
        i = 0;
        while (power_down !== 1'b0 && i < 60) begin
            step(1);
            i++;
        end
        if (i >= 60) give_up();
        step(6);
        chk(32'(cpu_stall), 32'h0000_0000);
        bound2();
        wait_vec(`IRQSC_VEC_PC, 0);
        print_verdict();
    end
endmodule

bind irqsc_top irqsc_checker u_chk (.pclk(pclk), .presetn(presetn), .sleep_cmd(sleep_cmd),
    .irq_return_instruction_cmd(irq_return_instruction_cmd), .cpu_stall(cpu_stall), .pc_push(pc_push), .pc_pop(pc_pop),
    .vec_load(vec_load), .vec_addr(vec_addr), .idle_mode(idle_mode),
    .power_down(power_down));
